// *** src/sevrep_defines.svh ***
// sevrep_defines.svh: offsets, bit positions and reset values for status reporting
// assumes inclusion by bare name from the modules
`ifndef SEVREP_DEFINES_SVH
`define SEVREP_DEFINES_SVH
// ----------------------------------------
// register selects on the command port
// ----------------------------------------
`define SEVREP_SEL_POLL     3'h0
`define SEVREP_SEL_STD      3'h1
`define SEVREP_SEL_CNT      3'h2
`define SEVREP_SEL_ERR      3'h3
`define SEVREP_SEL_POLL_EN  3'h4
`define SEVREP_SEL_STD_EN   3'h5
`define SEVREP_SEL_CNT_EN   3'h6
`define SEVREP_SEL_ERR_EN   3'h7
// ----------------------------------------
// serial-poll bit positions
// ----------------------------------------
`define SEVREP_SP_READY     0
`define SEVREP_SP_PRINT     1
`define SEVREP_SP_ERROR     2
`define SEVREP_SP_COUNTER   3
`define SEVREP_SP_QUEUE     4
`define SEVREP_SP_STD       5
`define SEVREP_SP_REQUEST   6
`define SEVREP_SP_SCAN      7
// ----------------------------------------
// standard event bit positions
// ----------------------------------------
`define SEVREP_SE_OPC       0
`define SEVREP_SE_QUERY     2
`define SEVREP_SE_EXEC      4
`define SEVREP_SE_CMD       5
`define SEVREP_SE_USER      6
`define SEVREP_SE_PON       7
`define SEVREP_SE_USED      8'hf5
`define SEVREP_CE_USED      8'h7f
// ----------------------------------------
// reset values
// ----------------------------------------
`define SEVREP_BYTE_RST     8'h00
`endif

// *** src/sevrep_pkg.sv ***
// sevrep_pkg.sv: types shared by the status reporting block
// assumes sevrep_defines.svh is on the include path
package sevrep_pkg;
   typedef logic [7:0] sevrep_byte_t;
   typedef logic [2:0] sevrep_sel_t;
   typedef logic [2:0] sevrep_bit_t;
   typedef enum logic [1:0] {
      SEVREP_OP_NONE  = 2'b00,
      SEVREP_OP_READ  = 2'b01,
      SEVREP_OP_BIT   = 2'b10,
      SEVREP_OP_WRITE = 2'b11
   } sevrep_op_t;
endpackage

// *** src/sevrep_event_byte.sv ***
// sevrep_event_byte.sv: one sticky event byte with mask and summary
// assumes read and clear strobes are one-cycle pulses on sys_clk
`timescale 1ns/10ps
`include "sevrep_defines.svh"
module sevrep_event_byte #(
   parameter logic [7:0] USED = 8'hff
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   arst_n,
   // event inputs
   input  wire sevrep_pkg::sevrep_byte_t set_bits,
   // clearing
   input  wire sevrep_pkg::sevrep_byte_t clr_bits,
   // mask
   input  wire sevrep_pkg::sevrep_byte_t mask,
   // state
   output sevrep_pkg::sevrep_byte_t   flags,
   output logic                       summary
);
   import sevrep_pkg::*;
   typedef struct packed {
      sevrep_byte_t flags;
      logic         summary;
   } sevrep_eb_state_t;
   sevrep_eb_state_t st;
   sevrep_eb_state_t next_st;
   // ----------------------------------------
   // latch, clear, summarise
   // ----------------------------------------
   always_comb begin
      next_st = st;
      // set wins over clear, unused bits stay zero
      next_st.flags = ((st.flags & ~clr_bits) | set_bits) & USED;
      // masked summary tracks current flags
      next_st.summary = |(next_st.flags & mask);
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign flags   = st.flags;
   assign summary = st.summary;
endmodule

// *** src/sevrep_poll_request.sv ***
// sevrep_poll_request.sv: serial-poll byte masking and request edge detect
// assumes all inputs are registered on sys_clk
`timescale 1ns/10ps
`include "sevrep_defines.svh"
module sevrep_poll_request (
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     arst_n,
   // sources
   input  wire sevrep_pkg::sevrep_byte_t raw_poll,
   input  wire sevrep_pkg::sevrep_byte_t poll_mask,
   input  wire logic                     clr_request,
   // results
   output logic                          request
);
   import sevrep_pkg::*;
   typedef struct packed {
      sevrep_byte_t prev;
      logic         request;
   } sevrep_pr_state_t;
   sevrep_pr_state_t st;
   sevrep_pr_state_t next_st;
   sevrep_byte_t     masked;
   // ----------------------------------------
   // rising enabled bit raises request
   // ----------------------------------------
   always_comb begin
      next_st = st;
      masked  = raw_poll & poll_mask;
      masked[`SEVREP_SP_REQUEST] = 1'b0;
      next_st.prev = masked;
      if (|(masked & ~st.prev)) begin
         next_st.request = 1'b1; // R10 R11 R23
      end else if (clr_request) begin
         next_st.request = 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign request = st.request;
endmodule

// *** src/sevrep_top.sv ***
// sevrep_top.sv: status event reporting for the instrument command layer
// assumes the command parser drives one-cycle operations synchronous to sys_clk
//
// Overview of operation
// (R1) serial-poll reads never change its contents
// (R2) error byte read returns then clears
// (R3) counter byte read returns then clears
// (R4) error enable mask written and read back
// (R5) counter enable mask written and read back
// (R6) poll bits 0,1,7 show idle states
// (R7) poll bits 2,3,5 are masked summaries
// (R8) poll bit 4 shows queue not empty
// (R9) summaries follow masked status continuously
// (R10) enabled poll bit set raises request
// (R11) request only on rising enabled bit
// (R12) std bit 2 queue overflow; 1,3 zero
// (R13) std bits 4,5 execution and command errors
// (R14) std bits 0,6,7 opc, user, power-on
// (R15) standard event bits latch until cleared
// (R16) counter bits 0-3 triggers and armed
// (R17) counter bits 4-6 overloads, bit 7 zero
// (R18) counter bits latch until read or clear
// (R19) power-on clears masks if pon-clear set
// (R20) clear-status clears bytes, keeps masks
// (R21) serial-poll enable mask host writable
// (R22) standard byte read returns then clears
// (R23) summaries are or of masked bytes
`timescale 1ns/10ps
`include "sevrep_defines.svh"
module sevrep_top (
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     arst_n,
   // power-on
   input  wire logic                     power_on_pulse,
   input  wire logic                     pon_clear,
   // command port
   input  wire sevrep_pkg::sevrep_op_t   cmd_op,
   input  wire sevrep_pkg::sevrep_sel_t  cmd_sel,
   input  wire sevrep_pkg::sevrep_bit_t  cmd_bit,
   input  wire sevrep_pkg::sevrep_byte_t cmd_wdata,
   input  wire logic                     clear_status,
   output sevrep_pkg::sevrep_byte_t      rsp_data,
   output logic                          rsp_valid,
   // standard events
   input  wire logic                     opc_done,
   input  wire logic                     queue_overflow,
   input  wire logic                     exec_error,
   input  wire logic                     cmd_error,
   input  wire logic                     user_request_flag,
   // counter events
   input  wire logic [6:0]               counter_events,
   // error events
   input  wire sevrep_pkg::sevrep_byte_t error_events,
   // activity
   input  wire logic                     meas_busy,
   input  wire logic                     print_busy,
   input  wire logic                     scan_busy,
   input  wire logic                     queue_not_empty,
   // outputs
   output sevrep_pkg::sevrep_byte_t      serial_poll_summary,
   output logic                          service_request
);
   import sevrep_pkg::*;
   typedef struct packed {
      sevrep_byte_t poll_en;
      sevrep_byte_t std_en;
      sevrep_byte_t cnt_en;
      sevrep_byte_t err_en;
      sevrep_byte_t rsp_data;
      logic         rsp_valid;
      sevrep_byte_t poll;
      logic         request;
   } sevrep_top_state_t;
   sevrep_top_state_t st;
   sevrep_top_state_t next_st;
   sevrep_byte_t std_flags;
   sevrep_byte_t cnt_flags;
   sevrep_byte_t err_flags;
   logic         std_sum;
   logic         cnt_sum;
   logic         err_sum;
   logic         request;
   sevrep_byte_t std_set;
   sevrep_byte_t cnt_set;
   sevrep_byte_t std_clr;
   sevrep_byte_t cnt_clr;
   sevrep_byte_t err_clr;
   sevrep_byte_t raw_poll;
   // ----------------------------------------
   // read clear mask for a selected byte
   // ----------------------------------------
   function automatic sevrep_byte_t read_clear(input sevrep_sel_t want, input sevrep_op_t op,
                                                input sevrep_sel_t sel, input sevrep_bit_t bitn,
                                                input logic cls);
      sevrep_byte_t m;
      m = 8'h00;
      if (sel == want && op == SEVREP_OP_READ) begin
         m = 8'hff;
      end else if (sel == want && op == SEVREP_OP_BIT) begin
         m = 8'h01 << bitn;
      end
      if (cls) begin
         m = 8'hff;
      end
      return m;
   endfunction
   // ----------------------------------------
   // event sources
   // ----------------------------------------
   always_comb begin
      std_set = 8'h00;
      std_set[`SEVREP_SE_OPC]   = opc_done;          // R14
      std_set[`SEVREP_SE_QUERY] = queue_overflow;    // R12
      std_set[`SEVREP_SE_EXEC]  = exec_error;        // R13
      std_set[`SEVREP_SE_CMD]   = cmd_error;         // R13
      std_set[`SEVREP_SE_USER]  = user_request_flag; // R14
      std_set[`SEVREP_SE_PON]   = power_on_pulse;    // R14
      cnt_set = {1'b0, counter_events};              // R16 R17
   end
   assign std_clr = read_clear(`SEVREP_SEL_STD, cmd_op, cmd_sel, cmd_bit, clear_status); // R22 R20 R15
   assign cnt_clr = read_clear(`SEVREP_SEL_CNT, cmd_op, cmd_sel, cmd_bit, clear_status); // R3 R20 R18
   assign err_clr = read_clear(`SEVREP_SEL_ERR, cmd_op, cmd_sel, cmd_bit, clear_status); // R2 R20
   // ----------------------------------------
   // event bytes
   // ----------------------------------------
   sevrep_event_byte #(.USED(`SEVREP_SE_USED)) u_std (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .set_bits (std_set),
      .clr_bits (std_clr),
      .mask     (st.std_en),
      .flags    (std_flags),
      .summary  (std_sum)
   );
   sevrep_event_byte #(.USED(`SEVREP_CE_USED)) u_cnt (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .set_bits (cnt_set),
      .clr_bits (cnt_clr),
      .mask     (st.cnt_en),
      .flags    (cnt_flags),
      .summary  (cnt_sum)
   );
   sevrep_event_byte #(.USED(8'hff)) u_err (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .set_bits (error_events),
      .clr_bits (err_clr),
      .mask     (st.err_en),
      .flags    (err_flags),
      .summary  (err_sum)
   );
   // ----------------------------------------
   // serial-poll assembly
   // ----------------------------------------
   always_comb begin
      raw_poll = 8'h00;
      raw_poll[`SEVREP_SP_READY]   = ~meas_busy;       // R6
      raw_poll[`SEVREP_SP_PRINT]   = ~print_busy;      // R6
      raw_poll[`SEVREP_SP_SCAN]    = ~scan_busy;       // R6
      raw_poll[`SEVREP_SP_ERROR]   = err_sum;          // R7 R9 R23
      raw_poll[`SEVREP_SP_COUNTER] = cnt_sum;          // R7 R9 R23
      raw_poll[`SEVREP_SP_STD]     = std_sum;          // R7 R9 R23
      raw_poll[`SEVREP_SP_QUEUE]   = queue_not_empty;  // R8
      raw_poll[`SEVREP_SP_REQUEST] = request;          // R10
   end
   sevrep_poll_request u_req (
      .sys_clk     (sys_clk),
      .arst_n      (arst_n),
      .raw_poll    (raw_poll),
      .poll_mask   (st.poll_en),
      .clr_request (clear_status),
      .request     (request)
   );
   // ----------------------------------------
   // masks, responses, outputs
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.rsp_valid = 1'b0;
      next_st.poll      = raw_poll;
      next_st.request   = request;
      if (power_on_pulse && pon_clear) begin
         next_st.poll_en = `SEVREP_BYTE_RST; // R19
         next_st.std_en  = `SEVREP_BYTE_RST; // R19
         next_st.cnt_en  = `SEVREP_BYTE_RST; // R19
         next_st.err_en  = `SEVREP_BYTE_RST; // R19
      end else if (cmd_op == SEVREP_OP_WRITE) begin
         unique case (cmd_sel)
            `SEVREP_SEL_POLL_EN: next_st.poll_en = cmd_wdata; // R21
            `SEVREP_SEL_STD_EN:  next_st.std_en  = cmd_wdata;
            `SEVREP_SEL_CNT_EN:  next_st.cnt_en  = cmd_wdata; // R5
            `SEVREP_SEL_ERR_EN:  next_st.err_en  = cmd_wdata; // R4
            default:             next_st.poll_en = st.poll_en;
         endcase
      end
      if (cmd_op == SEVREP_OP_READ || cmd_op == SEVREP_OP_BIT) begin
         next_st.rsp_valid = 1'b1;
         unique case (cmd_sel)
            `SEVREP_SEL_POLL:    next_st.rsp_data = raw_poll; // R1
            `SEVREP_SEL_STD:     next_st.rsp_data = std_flags;
            `SEVREP_SEL_CNT:     next_st.rsp_data = cnt_flags;
            `SEVREP_SEL_ERR:     next_st.rsp_data = err_flags;
            `SEVREP_SEL_POLL_EN: next_st.rsp_data = st.poll_en;
            `SEVREP_SEL_STD_EN:  next_st.rsp_data = st.std_en;
            `SEVREP_SEL_CNT_EN:  next_st.rsp_data = st.cnt_en;
            `SEVREP_SEL_ERR_EN:  next_st.rsp_data = st.err_en;
         endcase
         if (cmd_op == SEVREP_OP_BIT) begin
            next_st.rsp_data = {7'h00, next_st.rsp_data[cmd_bit]};
         end
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign rsp_data            = st.rsp_data;
   assign rsp_valid           = st.rsp_valid;
   assign serial_poll_summary = st.poll;
   assign service_request     = st.request;
endmodule

// *** tb/sevrep_checker_assertions.sv ***
// sevrep_checker_assertions.sv: port-level checks of status reporting
// assumes sevrep_top ports and the select codes of sevrep_defines.svh
`timescale 1ns/10ps
`include "sevrep_defines.svh"
module sevrep_checker (
   // clock and reset
   input wire logic                     sys_clk,
   input wire logic                     arst_n,
   // power-on and commands
   input wire logic                     power_on_pulse,
   input wire logic                     pon_clear,
   input wire sevrep_pkg::sevrep_op_t   cmd_op,
   input wire sevrep_pkg::sevrep_sel_t  cmd_sel,
   input wire sevrep_pkg::sevrep_byte_t cmd_wdata,
   input wire logic                     clear_status,
   input wire sevrep_pkg::sevrep_byte_t rsp_data,
   input wire logic                     rsp_valid,
   // status
   input wire logic                     meas_busy,
   input wire logic                     queue_not_empty,
   input wire sevrep_pkg::sevrep_byte_t serial_poll_summary,
   input wire logic                     service_request
);
   import sevrep_pkg::*;
   sevrep_byte_t poll_en;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // -------------------------------
   // shadow of the poll enable mask
   // -------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         poll_en <= 8'h00;
      end else if (power_on_pulse && pon_clear) begin
         poll_en <= 8'h00;
      end else if (cmd_op == SEVREP_OP_WRITE && cmd_sel == `SEVREP_SEL_POLL_EN) begin
         poll_en <= cmd_wdata;
      end
   end
   AST_BUSY_HIDES_READY: assert property (meas_busy [*3] |-> !serial_poll_summary[0])
      else $error("ready bit high while busy");
   AST_QUEUE_SHOWN: assert property ($rose(queue_not_empty) |-> ##[1:3] serial_poll_summary[4])
      else $error("queue bit missing");
   AST_REQ_RAISED: assert property ($rose(queue_not_empty) && poll_en[4] |-> ##[1:5] service_request)
      else $error("no service request");
   AST_REQ_HELD: assert property (service_request && !clear_status && !$past(clear_status) |=> service_request)
      else $error("service request dropped");
   AST_REQ_CLEARED: assert property (clear_status && poll_en == 8'h00 |-> ##[1:3] !service_request)
      else $error("request not cleared");
   AST_READ_ANSWERED: assert property (cmd_op inside {SEVREP_OP_READ, SEVREP_OP_BIT} |=> rsp_valid)
      else $error("read not answered");
   AST_WRITE_SILENT: assert property (cmd_op inside {SEVREP_OP_NONE, SEVREP_OP_WRITE} |=> !rsp_valid)
      else $error("answer without read");
   AST_BIT_READ_NARROW: assert property (cmd_op == SEVREP_OP_BIT |=> rsp_data[7:1] == 7'h00)
      else $error("bit read too wide");
   AST_STD_UNUSED_ZERO: assert property (cmd_op == SEVREP_OP_READ && cmd_sel == `SEVREP_SEL_STD
      |=> !rsp_data[1] && !rsp_data[3])
      else $error("unused standard bit set");
   cover property ($rose(service_request));
   cover property (cmd_op == SEVREP_OP_BIT);
   cover property (clear_status && service_request);
endmodule
bind sevrep_top sevrep_checker i_sevrep_checker (.sys_clk, .arst_n, .power_on_pulse, .pon_clear, .cmd_op,
   .cmd_sel, .cmd_wdata, .clear_status, .rsp_data, .rsp_valid, .meas_busy, .queue_not_empty,
   .serial_poll_summary, .service_request);

// *** tb/sevrep_host.sv ***
// sevrep_host.sv: host model issuing one-cycle commands
// assumes commands change on the falling edge of sys_clk
`timescale 1ns/10ps
module sevrep_host (
   // clock
   input  wire logic                     sys_clk,
   // command port
   output sevrep_pkg::sevrep_op_t        cmd_op,
   output sevrep_pkg::sevrep_sel_t       cmd_sel,
   output sevrep_pkg::sevrep_bit_t       cmd_bit,
   output sevrep_pkg::sevrep_byte_t      cmd_wdata,
   input  wire sevrep_pkg::sevrep_byte_t rsp_data,
   input  wire logic                     rsp_valid
);
   import sevrep_pkg::*;
   initial begin
      cmd_op = SEVREP_OP_NONE;
      cmd_sel = 3'h0;
      cmd_bit = 3'h0;
      cmd_wdata = 8'h00;
   end
   // one command, answer taken while rsp_valid stands
   task automatic access(input sevrep_op_t op, input sevrep_sel_t sel, input sevrep_bit_t bitn,
                         input sevrep_byte_t wd, output sevrep_byte_t rd);
      int n;
      @(negedge sys_clk);
      cmd_op = op;
      cmd_sel = sel;
      cmd_bit = bitn;
      cmd_wdata = wd;
      @(negedge sys_clk);
      cmd_op = SEVREP_OP_NONE;
      cmd_wdata = ~wd;
      n = 0;
      while (op != SEVREP_OP_WRITE && rsp_valid !== 1'b1 && n < 3) begin
         @(negedge sys_clk);
         n++;
      end
      rd = (rsp_valid === 1'b1) ? rsp_data : 8'hxx;
   endtask
endmodule

// *** tb/sevrep_top_tb_top.sv ***
// sevrep_top_tb_top.sv: self-checking bench for status reporting
// assumes sevrep_host drives the command port
`timescale 1ns/10ps
`include "sevrep_defines.svh"
module sevrep_top_tb_top;
   import sevrep_pkg::*;
   logic         sys_clk = 1'b0;
   logic         arst_n = 1'b0;
   logic         power_on_pulse = 1'b0;
   logic         pon_clear = 1'b0;
   logic         clear_status = 1'b0;
   logic [4:0]   std_ev = 5'h00;
   logic [6:0]   counter_events = 7'h00;
   sevrep_byte_t error_events = 8'h00;
   logic [2:0]   busy = 3'h0;
   logic         queue_not_empty = 1'b0;
   sevrep_op_t   cmd_op;
   sevrep_sel_t  cmd_sel;
   sevrep_bit_t  cmd_bit;
   sevrep_byte_t cmd_wdata, rsp_data, serial_poll_summary, rd;
   logic         rsp_valid, service_request;
   int           mismatches = 0;
   int           compares = 0;
   always #50 sys_clk = ~sys_clk;
   sevrep_top i_sevrep_top (.sys_clk, .arst_n, .power_on_pulse, .pon_clear, .cmd_op, .cmd_sel, .cmd_bit,
      .cmd_wdata, .clear_status, .rsp_data, .rsp_valid, .opc_done(std_ev[0]), .queue_overflow(std_ev[1]),
      .exec_error(std_ev[2]), .cmd_error(std_ev[3]), .user_request_flag(std_ev[4]), .counter_events,
      .error_events, .meas_busy(busy[0]), .print_busy(busy[1]), .scan_busy(busy[2]), .queue_not_empty,
      .serial_poll_summary, .service_request);
   sevrep_host i_sevrep_host (.sys_clk, .cmd_op, .cmd_sel, .cmd_bit, .cmd_wdata, .rsp_data, .rsp_valid);
   // ----------------
   // helpers
   // ----------------
   task automatic check(input sevrep_byte_t got, input sevrep_byte_t exp);
      compares++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic rd_chk(input sevrep_op_t op, input sevrep_sel_t sel, input sevrep_bit_t b, input sevrep_byte_t exp);
      i_sevrep_host.access(op, sel, b, 8'h00, rd);
      check(rd, exp);
   endtask
   task automatic wr(input sevrep_sel_t sel, input sevrep_byte_t wd);
      i_sevrep_host.access(SEVREP_OP_WRITE, sel, 3'h0, wd, rd);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #(3000 * 100);
      mismatches++;
      wrap_up();
   end
   // ----------------
   // tests
   // ----------------
   initial begin
      cyc(12);
      arst_n = 1'b1;
      cyc(2);
      for (int s = 4; s < 8; s++) begin
         rd_chk(SEVREP_OP_READ, 3'(s), 3'h0, 8'h00);
         wr(3'(s), 8'ha0 + 8'(s));
         rd_chk(SEVREP_OP_READ, 3'(s), 3'h0, 8'ha0 + 8'(s));
      end
      clear_status = 1'b1;
      std_ev = 5'h1f;
      power_on_pulse = 1'b1;
      cyc(1);
      {clear_status, std_ev, power_on_pulse} = 7'h00;
      cyc(4);
      check(serial_poll_summary & 8'h2c, 8'h20);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_STD, 3'h0, 8'hf5);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_STD, 3'h0, 8'h00);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_STD_EN, 3'h0, 8'ha5);
      $display("standard events done");
      counter_events = 7'h7f;
      cyc(1);
      counter_events = 7'h00;
      cyc(4);
      check(serial_poll_summary & 8'h2c, 8'h08);
      rd_chk(SEVREP_OP_BIT, `SEVREP_SEL_CNT, 3'h3, 8'h01);
      rd_chk(SEVREP_OP_BIT, `SEVREP_SEL_CNT, 3'h3, 8'h00);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_CNT, 3'h0, 8'h77);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_CNT, 3'h0, 8'h00);
      $display("counter events done");
      wr(`SEVREP_SEL_ERR_EN, 8'h01);
      error_events = 8'hff;
      cyc(1);
      error_events = 8'h00;
      cyc(4);
      check(serial_poll_summary & 8'h2c, 8'h04);
      rd_chk(SEVREP_OP_BIT, `SEVREP_SEL_ERR, 3'h0, 8'h01);
      cyc(4);
      check(serial_poll_summary & 8'h2c, 8'h00);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_ERR, 3'h0, 8'hfe);
      $display("error events done");
      wr(`SEVREP_SEL_POLL_EN, 8'h10);
      clear_status = 1'b1;
      cyc(1);
      clear_status = 1'b0;
      cyc(4);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_POLL, 3'h0, 8'h83);
      queue_not_empty = 1'b1;
      cyc(6);
      check({7'h00, service_request}, 8'h01);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_POLL, 3'h0, 8'hd3);
      rd_chk(SEVREP_OP_BIT, `SEVREP_SEL_POLL, 3'h6, 8'h01);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_POLL, 3'h0, 8'hd3);
      busy = 3'h7;
      cyc(4);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_POLL, 3'h0, 8'h50);
      busy = 3'h0;
      clear_status = 1'b1;
      cyc(1);
      clear_status = 1'b0;
      cyc(6);
      check({7'h00, service_request}, 8'h00);
      queue_not_empty = 1'b0;
      cyc(4);
      queue_not_empty = 1'b1;
      cyc(6);
      check({7'h00, service_request}, 8'h01);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_POLL_EN, 3'h0, 8'h10);
      $display("service request done");
      pon_clear = 1'b1;
      power_on_pulse = 1'b1;
      cyc(1);
      power_on_pulse = 1'b0;
      cyc(2);
      rd_chk(SEVREP_OP_READ, `SEVREP_SEL_ERR_EN, 3'h0, 8'h00);
      rd_chk(SEVREP_OP_BIT, `SEVREP_SEL_STD, 3'h7, 8'h01);
      clear_status = 1'b1;
      cyc(1);
      clear_status = 1'b0;
      cyc(3);
      check({7'h00, service_request}, 8'h00);
      $display("power-on clear done");
      wrap_up();
   end
endmodule
